// *** prm_defines.svh ***
`ifndef PRM_DEFINES_SVH
`define PRM_DEFINES_SVH

// ********************************************************
// timing
// ********************************************************
`define PRM_CLK_PERIOD_NS 32'h0000_0008
`define PRM_SEC_NS        32'h3B9A_CA00
`define PRM_SEC_CYCLES    (`PRM_SEC_NS / `PRM_CLK_PERIOD_NS)
`define PRM_MSG_SEC       2'h2

// ********************************************************
// sample window limits and reset values
// ********************************************************
`define PRM_WIN_MIN       5'h02
`define PRM_WIN_MAX       5'h18
`define PRM_WIN_RST       5'h02
`define PRM_KFAC_RST      16'h0001
`define PRM_SIG_RST       4'h0
`define PRM_WT_RST        7'h00
`define PRM_CODE_RST      16'h1000
`define PRM_LOCKT_RST     7'h00

// ********************************************************
// key codes and menu items
// ********************************************************
`define PRM_KEY_DIGIT_MAX 4'h9
`define PRM_KEY_START     4'hA
`define PRM_KEY_STOP      4'hB
`define PRM_ITEM_PRESET   4'h0
`define PRM_ITEM_PREWARN  4'h1

`endif

// *** prm_pkg.sv ***
package prm_pkg;

  // ********************************************************
  // types
  // ********************************************************
  // rate computation sequence
  typedef enum logic [1:0] {ST_IDLE, ST_RAW, ST_AVG, ST_TRUNC} prm_state_e;

  // front panel message
  typedef enum logic [2:0] {
    MSG_NONE, MSG_RUN_ARMED_MSG, MSG_SECURITY, MSG_LOCK_ON, MSG_LOCK_OFF
  } prm_msg_e;

  // stored setup
  typedef struct packed {
    logic [15:0] kfac;   // rate scale factor
    logic [4:0]  win;    // sample window, seconds
    logic [3:0]  sig;    // significant_digit_count, 0 shows all
    logic [6:0]  wt;     // averaging weight
    logic [15:0] code;   // lockout code, four bcd digits
    logic [6:0]  lockt;  // inactivity_lock_time, seconds
  } prm_cfg_s;

  // ********************************************************
  // decimal helpers
  // ********************************************************
  // power of ten, 0..9
  function automatic logic [31:0] pow10(input logic [3:0] n);
    case (n)
      4'h0:    pow10 = 32'h0000_0001;
      4'h1:    pow10 = 32'h0000_000A;
      4'h2:    pow10 = 32'h0000_0064;
      4'h3:    pow10 = 32'h0000_03E8;
      4'h4:    pow10 = 32'h0000_2710;
      4'h5:    pow10 = 32'h0001_86A0;
      4'h6:    pow10 = 32'h000F_4240;
      4'h7:    pow10 = 32'h0098_9680;
      4'h8:    pow10 = 32'h05F5_E100;
      default: pow10 = 32'h3B9A_CA00;
    endcase
  endfunction

  // count of decimal digits of a value, at least one
  function automatic logic [3:0] ndig(input logic [31:0] v);
    logic [3:0] n;
    n = 4'h1;
    for (int i = 1; i < 10; i++) begin
      if (v >= pow10(4'(i))) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

  // digits to drop so that only sig digits remain
  function automatic logic [3:0] drop_exp(input logic [31:0] v, input logic [3:0] sig);
    logic [3:0] n;
    n = ndig(v);
    if ((sig == 4'h0) || (n <= sig)) begin
      return 4'h0;
    end
    return n - sig;
  endfunction

endpackage

// *** prm_divider.sv ***
`timescale 1ns/1ps

// restoring divider, one quotient bit per cycle
module prm_divider (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // request
  input  wire logic        start,
  input  wire logic [31:0] num,
  input  wire logic [31:0] den,
  // answer
  output logic             done,
  output logic [31:0]      quo
);

  // ********************************************************
  // state
  // ********************************************************
  logic [31:0] q_ff;     // dividend shifting out, quotient in
  logic [31:0] rem_ff;   // partial remainder
  logic [31:0] den_ff;   // latched divisor
  logic [5:0]  cnt_ff;   // steps left
  logic        done_ff;  // one cycle after last step

  // trial subtraction; remainder stays below divisor so 33 bits suffice
  wire  [32:0] shifted = {rem_ff, q_ff[31]};
  wire         fits    = shifted >= {1'b0, den_ff};
  wire  [32:0] diff    = shifted - {1'b0, den_ff};

  // sequencing; a start while busy restarts, the caller never does so
  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff    <= 32'h0000_0000;
      rem_ff  <= 32'h0000_0000;
      den_ff  <= 32'h0000_0001;
      cnt_ff  <= 6'h00;
      done_ff <= 1'b0;
    end else if (start) begin
      q_ff    <= num;
      rem_ff  <= 32'h0000_0000;
      den_ff  <= den;
      cnt_ff  <= 6'h20;
      done_ff <= 1'b0;
    end else begin
      done_ff <= cnt_ff == 6'h01;
      if (cnt_ff != 6'h00) begin
        q_ff   <= {q_ff[30:0], fits};
        rem_ff <= fits ? diff[31:0] : shifted[31:0];
        cnt_ff <= cnt_ff - 6'h01;
      end
    end
  end

  assign done = done_ff;
  assign quo  = q_ff;

endmodule

// *** prm_keypad.sv ***
`timescale 1ns/1ps

// matches the last four digits keyed against the lockout code
module prm_keypad (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // key stream
  input  wire logic        digit_valid,
  input  wire logic [3:0]  digit,
  input  wire logic        clear,
  // stored code, bcd
  input  wire logic [15:0] code,
  // one cycle after the fourth matching digit
  output logic             match
);

  // ********************************************************
  // state
  // ********************************************************
  logic [15:0] buf_ff;    // last digits, newest low
  logic [2:0]  cnt_ff;    // digits held, saturates at four
  logic        match_ff;  // match pulse

  wire  [15:0] nxt_buf = {buf_ff[11:0], digit};
  wire         hit     = digit_valid && (cnt_ff >= 3'h3) && (nxt_buf == code);

  // shift digits; a hit empties the buffer so the same digits cannot toggle twice
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      buf_ff   <= 16'h0000;
      cnt_ff   <= 3'h0;
      match_ff <= 1'b0;
    end else begin
      match_ff <= hit;
      if (hit) begin
        buf_ff <= 16'h0000;
        cnt_ff <= 3'h0;
      end else if (digit_valid) begin
        buf_ff <= nxt_buf;
        cnt_ff <= (cnt_ff == 3'h4) ? 3'h4 : cnt_ff + 3'h1;
      end
    end
  end

  assign match = match_ff;

endmodule

// *** prm_monitor.sv ***
`timescale 1ns/1ps
`include "prm_defines.svh"

module prm_monitor
  import prm_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `PRM_SEC_CYCLES
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // flow input and options
  input  wire logic        PULSE_IN,
  input  wire logic        LIN16_OPT,
  // setup writes
  input  wire logic        CFG_K_WE,
  input  wire logic [15:0] CFG_K_VAL,
  input  wire logic        CFG_WIN_WE,
  input  wire logic [4:0]  CFG_WIN_VAL,
  input  wire logic        CFG_SIG_WE,
  input  wire logic [3:0]  CFG_SIG_VAL,
  input  wire logic        CFG_WT_WE,
  input  wire logic [6:0]  CFG_WT_VAL,
  input  wire logic        CFG_LOCK_WE,
  input  wire logic [15:0] CFG_CODE_VAL,
  input  wire logic [6:0]  CFG_LOCKT_VAL,
  // keypad and mode
  input  wire logic        KEY_VALID,
  input  wire logic [3:0]  KEY_CODE,
  input  wire logic        RUN_MODE,
  // menu access query
  input  wire logic [3:0]  MENU_ITEM,
  output logic             MENU_VIEW_OK,
  output logic             MENU_EDIT_OK,
  // rate display
  output logic [31:0]      RATE_OUT,
  output logic             RATE_UPD,
  // status
  output prm_msg_e         MSG_OUT,
  output logic             SEC_LOCKED,
  output logic             MENU_LOCKED,
  output logic             ARMED
);

  // ********************************************************
  // registers
  // ********************************************************
  prm_cfg_s    cfg_ff;        // stored setup
  logic [31:0] sec_cnt_ff;    // one second divider
  logic [15:0] pcnt_ff;       // pulses in current sample
  logic [4:0]  el_ff;         // seconds in current sample
  logic [15:0] s_cnt_ff;      // latched pulse count
  logic [4:0]  s_el_ff;       // latched sample time
  logic [31:0] raw_ff;        // raw rate sample
  logic [31:0] avg_ff;        // smoothed rate
  logic [31:0] rate_ff;       // truncated display value
  logic        upd_ff;        // display refreshed
  logic        go_ff;         // divider start
  prm_state_e  st_ff;         // computation step
  logic        armed_ff;      // run_armed_msg
  logic        sec_ff;        // security locked
  logic        menu_ff;       // menu lockout
  logic [6:0]  gap_ff;        // seconds since last pulse
  prm_msg_e    msg_ff;        // shown message
  logic [1:0]  msg_cnt_ff;    // seconds left for brief message
  logic        div_done;      // divider answer ready
  logic [31:0] div_quo;       // divider quotient
  logic        code_match;    // lockout code keyed

  // ********************************************************
  // decoding
  // ********************************************************
  wire         tick      = sec_cnt_ff == (SEC_CYCLES - 32'h0000_0001);
  wire  [4:0]  nxt_el    = el_ff + 5'h01;
  // sample is due when pulses came in or the window ran out
  wire         due       = tick && ((pcnt_ff != 16'h0000) || (nxt_el >= cfg_ff.win));
  wire         win_ok    = (CFG_WIN_VAL >= `PRM_WIN_MIN) && (CFG_WIN_VAL <= `PRM_WIN_MAX);
  wire         cfg_open  = !sec_ff && !menu_ff;
  wire         key_digit = KEY_VALID && (KEY_CODE <= `PRM_KEY_DIGIT_MAX);
  wire         key_start = KEY_VALID && (KEY_CODE == `PRM_KEY_START) && !sec_ff;
  wire         key_stop  = KEY_VALID && (KEY_CODE == `PRM_KEY_STOP) && !sec_ff;
  wire         key_other = KEY_VALID && !key_digit && !sec_ff;
  wire         feed      = key_digit && (sec_ff || RUN_MODE);
  wire         sec_rel   = code_match && sec_ff;
  wire         menu_tog  = code_match && !sec_ff && RUN_MODE;
  wire         timing    = armed_ff && !sec_ff && (cfg_ff.lockt != 7'h00);
  wire  [6:0]  nxt_gap   = gap_ff + 7'h01;
  wire         gap_hit   = timing && tick && !PULSE_IN && (nxt_gap >= cfg_ff.lockt);
  wire  [15:0] kfac_eff  = LIN16_OPT ? 16'h0001 : cfg_ff.kfac;
  wire  [31:0] wt32      = {25'h000_0000, cfg_ff.wt};
  wire  [3:0]  drop      = drop_exp(avg_ff, cfg_ff.sig);
  wire         is_pre    = MENU_ITEM == `PRM_ITEM_PRESET;
  wire         is_warn   = MENU_ITEM == `PRM_ITEM_PREWARN;

  // ********************************************************
  // divider operand select
  // ********************************************************
  logic [31:0] div_num;
  logic [31:0] div_den;
  assign div_num = (st_ff == ST_RAW) ? s_cnt_ff * kfac_eff :
                   (st_ff == ST_AVG) ? 32'(avg_ff * wt32) + raw_ff : avg_ff;
  assign div_den = (st_ff == ST_RAW) ? {27'h000_0000, s_el_ff} :
                   (st_ff == ST_AVG) ? wt32 + 32'h0000_0001 : pow10(drop);

  prm_divider u_div (
    .clk   (CORE_CLK),
    .rst   (RST),
    .start (go_ff),
    .num   (div_num),
    .den   (div_den),
    .done  (div_done),
    .quo   (div_quo)
  );

  prm_keypad u_key (
    .clk         (CORE_CLK),
    .rst         (RST),
    .digit_valid (feed),
    .digit       (KEY_CODE),
    .clear       (key_other),
    .code        (cfg_ff.code),
    .match       (code_match)
  );

  // ********************************************************
  // setup storage
  // ********************************************************
  // writes are blocked under any lock; menu lockout leaves none of these open
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_ff <= '{kfac: `PRM_KFAC_RST, win: `PRM_WIN_RST, sig: `PRM_SIG_RST,
                  wt: `PRM_WT_RST, code: `PRM_CODE_RST, lockt: `PRM_LOCKT_RST};
    end else if (cfg_open) begin
      if (CFG_K_WE && !LIN16_OPT) begin
        cfg_ff.kfac <= CFG_K_VAL;
      end
      if (CFG_WIN_WE && win_ok) begin
        cfg_ff.win <= CFG_WIN_VAL;
      end
      if (CFG_SIG_WE) begin
        cfg_ff.sig <= CFG_SIG_VAL;
      end
      if (CFG_WT_WE) begin
        cfg_ff.wt <= CFG_WT_VAL;
      end
      if (CFG_LOCK_WE) begin
        cfg_ff.code  <= CFG_CODE_VAL;
        cfg_ff.lockt <= CFG_LOCKT_VAL;
      end
    end
  end

  // ********************************************************
  // second divider and pulse accumulation
  // ********************************************************
  // a pulse in the capture cycle opens the next sample, it is never lost
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sec_cnt_ff <= 32'h0000_0000;
      pcnt_ff    <= 16'h0000;
      el_ff      <= 5'h00;
    end else begin
      sec_cnt_ff <= tick ? 32'h0000_0000 : sec_cnt_ff + 32'h0000_0001;
      if (due && (st_ff == ST_IDLE)) begin
        pcnt_ff <= {15'h0000, PULSE_IN};
        el_ff   <= 5'h00;
      end else begin
        if (PULSE_IN && (pcnt_ff != 16'hFFFF)) begin
          pcnt_ff <= pcnt_ff + 16'h0001;
        end
        if (tick && (el_ff != 5'h1F)) begin
          el_ff <= nxt_el;
        end
      end
    end
  end

  // ********************************************************
  // rate computation sequence
  // ********************************************************
  // three divisions take about a hundred cycles, far below one second
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_ff    <= ST_IDLE;
      go_ff    <= 1'b0;
      upd_ff   <= 1'b0;
      s_cnt_ff <= 16'h0000;
      s_el_ff  <= 5'h01;
      raw_ff   <= 32'h0000_0000;
      avg_ff   <= 32'h0000_0000;
      rate_ff  <= 32'h0000_0000;
    end else begin
      go_ff  <= 1'b0;
      upd_ff <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          if (due) begin
            s_cnt_ff <= pcnt_ff;
            s_el_ff  <= nxt_el;
            go_ff    <= 1'b1;
            st_ff    <= ST_RAW;
          end
        end
        ST_RAW: begin
          if (div_done) begin
            raw_ff <= div_quo;
            go_ff  <= 1'b1;
            st_ff  <= ST_AVG;
          end
        end
        ST_AVG: begin
          if (div_done) begin
            avg_ff <= div_quo;
            go_ff  <= 1'b1;
            st_ff  <= ST_TRUNC;
          end
        end
        ST_TRUNC: begin
          if (div_done) begin
            rate_ff <= 32'(div_quo * div_den);
            upd_ff  <= 1'b1;
            st_ff   <= ST_IDLE;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ********************************************************
  // inactivity timing and locks
  // ********************************************************
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      armed_ff <= 1'b0;
      sec_ff   <= 1'b0;
      menu_ff  <= 1'b0;
      gap_ff   <= 7'h00;
    end else if (sec_rel) begin
      sec_ff  <= 1'b0;
      menu_ff <= 1'b0;
      gap_ff  <= 7'h00;
    end else begin
      if (key_start) begin
        armed_ff <= 1'b1;
      end else if (key_stop) begin
        armed_ff <= 1'b0;
      end
      if (menu_tog) begin
        menu_ff <= !menu_ff;
      end
      if (timing && PULSE_IN) begin
        gap_ff <= 7'h00;
      end else if (gap_hit) begin
        sec_ff   <= 1'b1;
        armed_ff <= 1'b0;
        gap_ff   <= 7'h00;
      end else if (timing && tick) begin
        gap_ff <= nxt_gap;
      end
    end
  end

  // ********************************************************
  // messages
  // ********************************************************
  // brief messages last two second ticks; security stays until released
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      msg_ff     <= MSG_NONE;
      msg_cnt_ff <= 2'h0;
    end else if (gap_hit) begin
      msg_ff <= MSG_SECURITY;
    end else if (sec_rel) begin
      msg_ff <= MSG_NONE;
    end else if (!sec_ff && (key_start || menu_tog)) begin
      msg_ff     <= key_start ? MSG_RUN_ARMED_MSG : (menu_ff ? MSG_LOCK_OFF : MSG_LOCK_ON);
      msg_cnt_ff <= `PRM_MSG_SEC;
    end else if (!sec_ff && tick) begin
      msg_cnt_ff <= (msg_cnt_ff == 2'h0) ? 2'h0 : msg_cnt_ff - 2'h1;
      if (msg_cnt_ff <= 2'h1) begin
        msg_ff <= MSG_NONE;
      end
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  // preset edit, prewarn view
  assign MENU_VIEW_OK = !sec_ff && (!menu_ff || is_pre || is_warn);
  assign MENU_EDIT_OK = !sec_ff && (!menu_ff || is_pre);
  assign RATE_OUT     = rate_ff;
  assign RATE_UPD     = upd_ff;
  assign MSG_OUT      = msg_ff;
  assign SEC_LOCKED   = sec_ff;
  assign MENU_LOCKED  = menu_ff;
  assign ARMED        = armed_ff;

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence seq_start_key;
    key_start && !code_match && !gap_hit;
  endsequence
  sequence seq_run_armed_msg_shown;
    ARMED && (MSG_OUT == MSG_RUN_ARMED_MSG);
  endsequence

  chk_rate_refresh: assert property (
    due && (st_ff == ST_IDLE) |-> ##[100:110] RATE_UPD) else $error("rate not refreshed");
  chk_rate_hold: assert property (
    (st_ff == ST_IDLE) && !due |=> !RATE_UPD && $stable(RATE_OUT))
    else $error("rate moved without sample");
  chk_window_range: assert property (
    CFG_WIN_WE && !win_ok |=> $stable(cfg_ff.win)) else $error("bad window taken");
  chk_kfac_skip: assert property (
    LIN16_OPT |=> $stable(cfg_ff.kfac)) else $error("factor written with option");
  chk_sig_digits: assert property (
    RATE_UPD && (cfg_ff.sig != 4'h0) |-> (RATE_OUT <= avg_ff) &&
    ((avg_ff - RATE_OUT) < pow10(drop)) && ((RATE_OUT % pow10(drop)) == 32'h0000_0000))
    else $error("digits not truncated");
  chk_reset_code: assert property (
    $fell(RST) |-> (cfg_ff.code == 16'h1000) && (cfg_ff.lockt == 7'h00))
    else $error("bad lockout defaults");
  chk_start_msg: assert property (
    seq_start_key |=> seq_run_armed_msg_shown) else $error("start not shown");
  chk_gap_clear: assert property (
    timing && PULSE_IN && !sec_rel |=> gap_ff == 7'h00) else $error("gap not cleared");
  chk_sec_lock: assert property (
    gap_hit && !sec_rel |=> SEC_LOCKED && (MSG_OUT == MSG_SECURITY) && !ARMED)
    else $error("no security lock");
  chk_digit_only: assert property (
    SEC_LOCKED && KEY_VALID && !key_digit && !code_match |=> SEC_LOCKED && !ARMED)
    else $error("key acted while locked");
  chk_sec_release: assert property (
    SEC_LOCKED && code_match |=> !SEC_LOCKED && !MENU_LOCKED) else $error("no release");
  chk_stop_keep: assert property (
    key_stop && !PULSE_IN && !tick && !code_match |=> !ARMED && $stable(gap_ff))
    else $error("stop lost gap");
  chk_zero_time: assert property (
    (cfg_ff.lockt == 7'h00) && !SEC_LOCKED |=> !SEC_LOCKED) else $error("locked at zero");
  chk_menu_toggle: assert property (
    menu_tog && !MENU_LOCKED && !key_start && !gap_hit |=> MENU_LOCKED &&
    (MSG_OUT == MSG_LOCK_ON)) else $error("lockout not engaged");
  chk_menu_view: assert property (
    MENU_LOCKED && !SEC_LOCKED && is_warn |-> MENU_VIEW_OK && !MENU_EDIT_OK)
    else $error("prewarn access wrong");
  chk_menu_release: assert property (
    menu_tog && MENU_LOCKED && !key_start && !gap_hit |=> !MENU_LOCKED &&
    (MSG_OUT == MSG_LOCK_OFF)) else $error("lockout not released");

endmodule

// *** prm_flow_model.sv ***
`timescale 1ns/1ps

// ********************************************************
// flowmeter sensor and front panel keypad
// ********************************************************
module prm_flow_model (
  // clock
  input  wire logic       clk,
  // sensor and keys
  output logic            pulse,
  output logic            key_valid,
  output logic [3:0]      key_code
);
  int unsigned period = 0;  // cycles between pulses, 0 stops the flow
  int unsigned cnt    = 0;  // phase within the pulse period

  initial begin
    pulse     = 1'b0;
    key_valid = 1'b0;
    key_code  = 4'h0;
  end

  // one high cycle per pulse, so every second holds the same count
  always @(posedge clk) begin
    cnt   <= (cnt + 1 >= period) ? 0 : cnt + 1;
    pulse <= (period != 0) && (cnt == 0);
  end

  // one key stroke; a released code shows its inverse, never the old value
  task automatic press(input logic [3:0] k);
    @(posedge clk);
    key_valid <= 1'b1;
    key_code  <= k;
    @(posedge clk);
    key_valid <= 1'b0;
    key_code  <= ~k;
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`include "prm_defines.svh"

// ********************************************************
// rate monitor bench
// ********************************************************
module testbench;
  import prm_pkg::*;
  localparam int SEC = 120;  // short second, still longer than one update
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        lin  = 1'b0;
  logic        run  = 1'b1;
  logic [4:0]  we   = 5'h00;  // k, window, sig, weight, lock strobes
  logic [3:0]  item = 4'h0;
  prm_cfg_s    cv   = '0;     // next setup, staged by the scenarios
  prm_cfg_s    cvd  = '0;     // setup on the pins
  logic        pulse, kvld, upd, view_ok, edit_ok, seclk, menulk, armed;
  logic [3:0]  kcode;
  logic [31:0] rate, a, k;
  prm_msg_e    msg;
  int          errors = 0, check_count = 0, t0 = 0, t1 = 0, n = 0, cyc = 0;

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  prm_flow_model prm_flow_model_inst (.clk(clk), .pulse(pulse), .key_valid(kvld),
    .key_code(kcode));
  prm_monitor #(.SEC_CYCLES(SEC)) prm_monitor_inst (.CORE_CLK(clk), .RST(rst),
    .PULSE_IN(pulse), .LIN16_OPT(lin), .CFG_K_WE(we[4]), .CFG_K_VAL(cvd.kfac),
    .CFG_WIN_WE(we[3]), .CFG_WIN_VAL(cvd.win), .CFG_SIG_WE(we[2]), .CFG_SIG_VAL(cvd.sig),
    .CFG_WT_WE(we[1]), .CFG_WT_VAL(cvd.wt), .CFG_LOCK_WE(we[0]), .CFG_CODE_VAL(cvd.code),
    .CFG_LOCKT_VAL(cvd.lockt), .KEY_VALID(kvld), .KEY_CODE(kcode), .RUN_MODE(run),
    .MENU_ITEM(item), .MENU_VIEW_OK(view_ok), .MENU_EDIT_OK(edit_ok), .RATE_OUT(rate),
    .RATE_UPD(upd), .MSG_OUT(msg), .SEC_LOCKED(seclk), .MENU_LOCKED(menulk), .ARMED(armed));

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if ((errors == 0) && (check_count > 0)) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (e !== g) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle write of the staged setup through the chosen strobes
  task automatic cfg(input logic [4:0] s);
    @(posedge clk);
    we  <= s;
    cvd <= cv;
    @(posedge clk);
    we  <= 5'h00;
  endtask

  // bounded wait for a refresh, keeps the spacing of the last two
  task automatic wait_upd();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((upd !== 1'b1) && (n < 800));
    if (n >= 800) chk("rate_upd_timeout", 1, 0);
    t0 = t1;
    t1 = cyc;
  endtask

  // four digits, oldest first; the lock flags land two cycles after the last
  task automatic keys(input logic [15:0] c);
    for (int i = 3; i >= 0; i--) prm_flow_model_inst.press(c[4*i +: 4]);
    repeat (3) @(negedge clk);
  endtask

  // truncation to s digits, worked out without the design's helpers
  function automatic logic [31:0] trunc(input logic [31:0] v, input int s);
    longint p;
    int     nd;
    p  = 1;
    nd = 1;
    while (v >= p * 10) begin
      p = p * 10;
      nd++;
    end
    if ((s == 0) || (nd <= s)) return v;
    p = 1;
    repeat (nd - s) p = p * 10;
    return 32'((v / p) * p);
  endfunction

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    test_done();
  end

  initial begin
    void'($urandom(15492));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset_state", 0, {msg, seclk, menulk, armed, upd, rate});
    keys(16'h1000);
    chk("menu_lock_on", {1'b1, MSG_LOCK_ON}, {menulk, msg});
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      item <= 4'(i);
      @(negedge clk);
      chk("view_ok", (i < 2), view_ok);
      chk("edit_ok", (i == 0), edit_ok);
    end
    keys(16'h1000);
    chk("menu_lock_off", {1'b0, MSG_LOCK_OFF}, {menulk, msg});
    // outside run mode the code must not engage the lockout
    @(posedge clk);
    run <= 1'b0;
    keys(16'h1000);
    chk("no_lock_out_of_run", 0, menulk);
    @(posedge clk);
    run <= 1'b1;
    // steady flow, then out-of-range windows that must be refused
    prm_flow_model_inst.period = 8;
    k = $urandom_range(999, 100);
    cv.kfac = k[15:0];
    cv.win = 5'h05;
    cfg(5'b11110);
    cv.win = 5'h19;
    cfg(5'b01000);
    cv.win = 5'h01;
    cfg(5'b01000);
    repeat (2) wait_upd();
    repeat (3) begin
      wait_upd();
      chk("rate", 15 * k, rate);
      chk("interval", SEC, t1 - t0);
    end
    // a step in the raw rate shows the weighting
    a = 15 * k;
    cv.wt = 7'($urandom_range(7, 1));
    k = $urandom_range(999, 100);
    cv.kfac = k[15:0];
    cfg(5'b10010);
    repeat (3) begin
      wait_upd();
      a = (a * cv.wt + 15 * k) / (cv.wt + 1);
      chk("avg", a, rate);
    end
    cv.wt = 7'h00;
    cv.sig = 4'($urandom_range(3, 1));
    cfg(5'b00110);
    wait_upd();
    chk("sig_digits", trunc(15 * k, cv.sig), rate);
    @(posedge clk);
    lin <= 1'b1;
    cv.kfac = 16'h0077;
    cv.sig = 4'h0;
    cfg(5'b10100);
    wait_upd();
    chk("lin16_rate", 15, rate);
    // flow stops: one last refresh, then a hold for the whole window
    prm_flow_model_inst.period = 0;
    repeat (2) wait_upd();
    chk("window_hold", 5 * SEC, t1 - t0);
    chk("expiry_rate", 0, rate);
    for (int i = 0; i < 4; i++) cv.code[4*i +: 4] = 4'($urandom_range(9, 0));
    cv.lockt = 7'h04;
    cfg(5'b00001);
    prm_flow_model_inst.press(`PRM_KEY_START);
    @(negedge clk);
    chk("run_armed_msg", {1'b1, MSG_RUN_ARMED_MSG}, {armed, msg});
    repeat (250) @(negedge clk);
    prm_flow_model_inst.press(`PRM_KEY_STOP);
    repeat (600) @(negedge clk);
    chk("stopped_unlocked", 0, seclk);
    prm_flow_model_inst.press(`PRM_KEY_START);
    n = 0;
    while ((seclk !== 1'b1) && (n < 300)) begin
      @(negedge clk);
      n++;
    end
    chk("resumed_lock", {1'b1, MSG_SECURITY}, {seclk, msg});
    prm_flow_model_inst.press(`PRM_KEY_START);
    @(negedge clk);
    chk("locked_ignores_start", 0, armed);
    keys(cv.code);
    chk("code_unlocks", 0, seclk);
    // steady pulses keep clearing the gap, so no lock in five seconds
    prm_flow_model_inst.period = 8;
    prm_flow_model_inst.press(`PRM_KEY_START);
    repeat (600) @(negedge clk);
    chk("pulse_clears_gap", 0, seclk);
    prm_flow_model_inst.period = 0;
    cv.lockt = 7'h00;
    cfg(5'b00001);
    prm_flow_model_inst.press(`PRM_KEY_START);
    repeat (600) @(negedge clk);
    chk("zero_time_no_lock", 0, seclk);
    test_done();
  end
endmodule
